// ==== inc/fpf_pkg.sv ====
package fpf_pkg;
   // ----------------------------------------
   // Issue codes and timing
   // ----------------------------------------
   localparam logic [7:0] OP_ADD_FLAGS = 8'h70;
   localparam logic [7:0] OP_DIVIDE = 8'h6C;
   localparam logic [7:0] OP_DIV_FLAGS = 8'h6D;
   localparam int ALU_LATENCY = 3;
   localparam int DIV_LATENCY = 17;
   localparam int DIV_RECOVERY = 16;
   localparam int QUOT_BITS = 26;
   localparam int QUOT_STEPS = 2;
   // ----------------------------------------
   // Exception vector layout
   // ----------------------------------------
   localparam int FLAG_W = 7;
   localparam int F_OUT_FLUSH = 6;
   localparam int F_IN_FLUSH = 5;
   localparam int F_BAD_OPERAND = 4;
   localparam int F_OVERFLOW = 3;
   localparam int F_UNDERFLOW = 2;
   localparam int F_INEXACT = 1;
   localparam int F_DIV_BY_ZERO = 0;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;
   // ----------------------------------------
   // Rounding modes and float constants
   // ----------------------------------------
   localparam logic [1:0] RM_NEAREST = 2'h0;
   localparam logic [1:0] RM_TO_ZERO = 2'h1;
   localparam logic [1:0] RM_POS_INF = 2'h2;
   localparam logic [1:0] RM_NEG_INF = 2'h3;
   localparam logic [31:0] QUIET_NAN = 32'hFFFFFFFF;
   localparam logic [30:0] INF_MAG = 31'h7F800000;
   localparam logic [30:0] MAX_MAG = 31'h7F7FFFFF;
   localparam logic [7:0] EXP_MAX = 8'hFF;
   localparam logic signed [9:0] EXP_BIAS = 10'sh07F;
   localparam logic signed [9:0] EXP_TOP = 10'sh0FF;
endpackage

// ==== logic/fpf_divcore.sv ====
module fpf_divcore
   import fpf_pkg::*;
#(
   parameter int QW = QUOT_BITS,
   parameter int STEPS = QUOT_STEPS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic start,
   input wire logic [24:0] dividend,
   input wire logic [23:0] divisor,
   output logic [QW-1:0] quotient,
   output logic rem_nonzero,
   output logic done
);
   // ----------------------------------------
   // Restoring divider, STEPS bits a cycle
   // ----------------------------------------
   localparam int CYCLES = QW / STEPS;
   logic [24:0] rem, next_rem;
   logic [23:0] dv, next_dv;
   logic [QW-1:0] next_quotient;
   logic [4:0] cnt, next_cnt;
   logic busy, next_busy, next_done;

   always_comb begin
      next_rem = rem;
      next_dv = dv;
      next_quotient = quotient;
      next_cnt = cnt;
      next_busy = busy;
      next_done = 1'b0;
      if (start) begin
         next_rem = dividend;
         next_dv = divisor;
         next_cnt = 5'(CYCLES - 1);
         next_busy = 1'b1;
      end else if (busy) begin
         for (int i = 0; i < STEPS; i++) begin
            // Remainder stays below divisor, so the shift never overflows
            if (next_rem >= {1'b0, next_dv}) begin
               next_rem = next_rem - {1'b0, next_dv};
               next_quotient = {next_quotient[QW-2:0], 1'b1};
            end else begin
               next_quotient = {next_quotient[QW-2:0], 1'b0};
            end
            next_rem = {next_rem[23:0], 1'b0};
         end
         next_cnt = cnt - 5'h01;
         if (cnt == 5'h00) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rem <= '0;
         dv <= '0;
         quotient <= '0;
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         rem <= next_rem;
         dv <= next_dv;
         quotient <= next_quotient;
         cnt <= next_cnt;
         busy <= next_busy;
         done <= next_done;
      end
   end

   assign rem_nonzero = |rem;
endmodule

// ==== logic/fpf_unit.sv ====
// Notes on behaviour
// - Add flags op returns would-be exception vector
// - Vector bits six to zero, upper bits zero
// - Flags-only ops leave status flags untouched
// - Rounding follows status word rounding mode
// - Add flags: denormal sources flushed, input-flush
// - Add flags: denormal sum sets output-flush
// - Divide flags: same input/output flush handling
// - Guard LSB one writes destination, else not
// - Divide writes single-precision quotient
// - Divide flushes denormal sources, sets input-flush
// - Denormal quotient becomes zero, output-flush set
// - Divide exceptions set sticky status flags
// - Flag update lands the cycle after destination write
// - Simultaneous updates OR together; a status write replaces previous flags
// - False guard blocks destination and flags
// - Add flags: opcode 112, latency 3
// - Divide: opcode 108, latency 17, recovery 16
// - Divide flags: opcode 109, latency 17, recovery 16
module fpf_unit
   import fpf_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic [1:0] ROUND_MODE,
   input wire logic ALU_ISSUE,
   input wire logic [7:0] ALU_OPCODE,
   input wire logic [31:0] ALU_FIRST_SOURCE,
   input wire logic [31:0] ALU_SECOND_SOURCE,
   input wire logic ALU_GUARD,
   output logic ALU_WB_VALID,
   output logic [31:0] ALU_WB_DATA,
   input wire logic DIV_ISSUE,
   input wire logic [7:0] DIV_OPCODE,
   input wire logic [31:0] DIV_FIRST_SOURCE,
   input wire logic [31:0] DIV_SECOND_SOURCE,
   input wire logic DIV_GUARD,
   output logic DIV_READY,
   output logic DIV_WB_VALID,
   output logic [31:0] DIV_WB_DATA,
   input wire logic PSW_WRITE,
   input wire logic [FLAG_W-1:0] PSW_WRITE_FLAGS,
   input wire logic [FLAG_W-1:0] OTHER_FLAG_SET,
   output logic [FLAG_W-1:0] PROGRAM_STATUS_WORD_FLAGS
);
   // ----------------------------------------
   // Shared float helpers
   // ----------------------------------------
   // Denormals count as zero everywhere in this unit
   function automatic logic is_denorm(input logic [31:0] x);
      return (x[30:23] == 8'h00) && (x[22:0] != 23'h0);
   endfunction

   function automatic logic [31:0] flush(input logic [31:0] x);
      return is_denorm(x) ? {x[31], 31'h0} : x;
   endfunction

   function automatic logic is_nan(input logic [31:0] x);
      return (x[30:23] == EXP_MAX) && (x[22:0] != 23'h0);
   endfunction

   function automatic logic is_snan(input logic [31:0] x);
      return is_nan(x) && !x[22];
   endfunction

   function automatic logic is_inf(input logic [31:0] x);
      return x[30:0] == INF_MAG;
   endfunction

   // Mantissa m has its leading one at bit 26, then guard, round, sticky
   function automatic logic [FLAG_W+31:0] round_pack(
         input logic s, input logic signed [9:0] e,
         input logic [26:0] m, input logic [1:0] rm);
      logic inexact_flag;
      logic inc;
      logic up;
      logic [24:0] mr;
      logic signed [9:0] ex;
      logic [FLAG_W-1:0] f;
      logic [31:0] r;
      f = '0;
      inexact_flag = |m[2:0];
      case (rm)
         RM_NEAREST: inc = m[2] & (m[1] | m[0] | m[3]);
         RM_POS_INF: inc = !s & inexact_flag;
         RM_NEG_INF: inc = s & inexact_flag;
         default: inc = 1'b0;
      endcase
      up = (rm == RM_NEAREST) || (rm == RM_POS_INF && !s) ||
           (rm == RM_NEG_INF && s);
      mr = {1'b0, m[26:3]} + {24'h0, inc};
      ex = e;
      if (mr[24]) begin
         mr = mr >> 1;
         ex = ex + 10'sh001;
      end
      r = {s, ex[7:0], mr[22:0]};
      if (m == 27'h0) begin
         r = {s, 31'h0};
      end else if (ex >= EXP_TOP) begin
         f[F_OVERFLOW] = 1'b1;
         f[F_INEXACT] = 1'b1;
         r = {s, up ? INF_MAG : MAX_MAG};
      end else if (ex <= 10'sh000) begin
         // Tiny results are never kept as denormals
         f[F_OUT_FLUSH] = 1'b1;
         f[F_UNDERFLOW] = 1'b1;
         f[F_INEXACT] = 1'b1;
         r = {s, 31'h0};
      end else begin
         f[F_INEXACT] = inexact_flag;
      end
      return {f, r};
   endfunction

   // ----------------------------------------
   // Add flags path
   // ----------------------------------------
   logic [31:0] aa, ab, big, sml;
   logic [7:0] dexp;
   logic [26:0] mbig, msml, lost;
   logic [27:0] sum;
   logic [26:0] mnorm;
   logic signed [9:0] enorm;
   logic [FLAG_W-1:0] add_flags;
   logic [FLAG_W+31:0] add_pack;
   int lz;

   always_comb begin
      aa = flush(ALU_FIRST_SOURCE);
      ab = flush(ALU_SECOND_SOURCE);
      big = (aa[30:0] >= ab[30:0]) ? aa : ab;
      sml = (aa[30:0] >= ab[30:0]) ? ab : aa;
      dexp = big[30:23] - sml[30:23];
      mbig = {big[30:23] != 8'h00, big[22:0], 3'h0};
      msml = {sml[30:23] != 8'h00, sml[22:0], 3'h0};
      lost = '0;
      if (dexp > 8'h1A) begin
         lost = msml;
         msml = '0;
      end else begin
         lost = msml & ((27'h1 << dexp) - 27'h1);
         msml = msml >> dexp;
      end
      msml[0] = msml[0] | (|lost);
      sum = (big[31] == sml[31]) ? {1'b0, mbig} + {1'b0, msml}
                                 : {1'b0, mbig} - {1'b0, msml};
      lz = 0;
      for (int i = 26; i >= 0; i--) begin
         if (sum[i] && lz == 0) begin
            lz = 27 - i;
         end
      end
      if (sum[27]) begin
         mnorm = {sum[27:2], |sum[1:0]};
         enorm = $signed({2'b00, big[30:23]}) + 10'sh001;
      end else begin
         mnorm = (lz == 0) ? 27'h0 : sum[26:0] << (lz - 1);
         enorm = $signed({2'b00, big[30:23]}) - 10'(lz - 1);
      end
      add_pack = round_pack(big[31], enorm, mnorm, ROUND_MODE);
      add_flags = add_pack[FLAG_W+31:32];
      if (is_nan(aa) || is_nan(ab) || is_inf(aa) || is_inf(ab)) begin
         add_flags = '0;
         add_flags[F_BAD_OPERAND] = is_snan(aa) || is_snan(ab) ||
            (is_inf(aa) && is_inf(ab) && aa[31] != ab[31]);
      end
      add_flags[F_IN_FLUSH] = is_denorm(ALU_FIRST_SOURCE) ||
                              is_denorm(ALU_SECOND_SOURCE);
   end

   // ----------------------------------------
   // Add flags pipeline
   // ----------------------------------------
   logic [ALU_LATENCY-1:0] alu_v, next_alu_v;
   logic [FLAG_W-1:0] alu_f [ALU_LATENCY];
   logic [FLAG_W-1:0] next_alu_f [ALU_LATENCY];

   always_comb begin
      // False guard simply drops the token
      next_alu_v = {alu_v[ALU_LATENCY-2:0],
         ALU_ISSUE && ALU_OPCODE == OP_ADD_FLAGS && ALU_GUARD};
      next_alu_f[0] = add_flags;
      for (int i = 1; i < ALU_LATENCY; i++) begin
         next_alu_f[i] = alu_f[i-1];
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         alu_v <= '0;
         for (int i = 0; i < ALU_LATENCY; i++) begin
            alu_f[i] <= '0;
         end
      end else if (CE) begin
         alu_v <= next_alu_v;
         alu_f <= next_alu_f;
      end
   end

   assign ALU_WB_VALID = alu_v[ALU_LATENCY-1];
   assign ALU_WB_DATA = {25'h0, alu_f[ALU_LATENCY-1]};

   // ----------------------------------------
   // Divide issue and special cases
   // ----------------------------------------
   logic [31:0] da, db, spec_res;
   logic [FLAG_W-1:0] spec_flags;
   logic spec_hit, div_take;
   logic [24:0] dvd;
   logic signed [9:0] dexp_q;
   logic [4:0] recov, next_recov;

   // Issuer must respect the recovery gap; early issues are dropped
   assign DIV_READY = (recov == 5'h00);
   assign div_take = DIV_ISSUE && DIV_READY &&
      (DIV_OPCODE == OP_DIVIDE || DIV_OPCODE == OP_DIV_FLAGS);

   always_comb begin
      da = flush(DIV_FIRST_SOURCE);
      db = flush(DIV_SECOND_SOURCE);
      spec_hit = 1'b1;
      spec_flags = '0;
      spec_res = {da[31] ^ db[31], 31'h0};
      if (is_nan(da) || is_nan(db)) begin
         spec_res = QUIET_NAN;
         spec_flags[F_BAD_OPERAND] = is_snan(da) || is_snan(db);
      end else if ((is_inf(da) && is_inf(db)) ||
                   (da[30:0] == 31'h0 && db[30:0] == 31'h0)) begin
         spec_res = QUIET_NAN;
         spec_flags[F_BAD_OPERAND] = 1'b1;
      end else if (is_inf(da)) begin
         spec_res[30:0] = INF_MAG;
      end else if (db[30:0] == 31'h0) begin
         spec_res[30:0] = INF_MAG;
         spec_flags[F_DIV_BY_ZERO] = 1'b1;
      end else if (da[30:0] != 31'h0 && !is_inf(db)) begin
         spec_hit = 1'b0;
      end
      spec_flags[F_IN_FLUSH] = is_denorm(DIV_FIRST_SOURCE) ||
                               is_denorm(DIV_SECOND_SOURCE);
      // Pre-scale so the quotient's leading one lands at the top bit
      dexp_q = $signed({2'b00, da[30:23]}) - $signed({2'b00, db[30:23]})
               + EXP_BIAS;
      if (da[22:0] < db[22:0]) begin
         dvd = {1'b1, da[22:0], 1'b0};
         dexp_q = dexp_q - 10'sh001;
      end else begin
         dvd = {2'b01, da[22:0]};
      end
      next_recov = div_take ? 5'(DIV_RECOVERY - 1) :
                   (recov != 5'h00) ? recov - 5'h01 : recov;
   end

   // ----------------------------------------
   // Divide core and result hold
   // ----------------------------------------
   logic [QUOT_BITS-1:0] quot;
   logic quot_sticky, quot_done;

   fpf_divcore #(.QW(QUOT_BITS), .STEPS(QUOT_STEPS)) u_core (
      .clk(CLK),
      .rst(SYS_RST),
      .ce(CE),
      .start(div_take),
      .dividend(dvd),
      .divisor({1'b1, db[22:0]}),
      .quotient(quot),
      .rem_nonzero(quot_sticky),
      .done(quot_done)
   );

   logic op_flags_only, op_guard, op_spec, op_sign;
   logic next_op_flags_only, next_op_guard, next_op_spec, next_op_sign;
   logic [31:0] op_spec_res, next_op_spec_res;
   logic [FLAG_W-1:0] op_spec_flags, next_op_spec_flags;
   logic signed [9:0] op_exp, next_op_exp;
   logic [1:0] op_rm, next_op_rm;
   logic [DIV_LATENCY-1:0] tok, next_tok;
   logic res_flags_only, res_guard, next_res_flags_only, next_res_guard;
   logic [31:0] res_data, next_res_data;
   logic [FLAG_W-1:0] res_flags, next_res_flags;
   logic [FLAG_W+31:0] div_pack;

   always_comb begin
      next_op_flags_only = op_flags_only;
      next_op_guard = op_guard;
      next_op_spec = op_spec;
      next_op_sign = op_sign;
      next_op_spec_res = op_spec_res;
      next_op_spec_flags = op_spec_flags;
      next_op_exp = op_exp;
      next_op_rm = op_rm;
      if (div_take) begin
         next_op_flags_only = DIV_OPCODE == OP_DIV_FLAGS;
         next_op_guard = DIV_GUARD;
         next_op_spec = spec_hit;
         next_op_sign = da[31] ^ db[31];
         next_op_spec_res = spec_res;
         next_op_spec_flags = spec_flags;
         next_op_exp = dexp_q;
         next_op_rm = ROUND_MODE;
      end
      next_tok = {tok[DIV_LATENCY-2:0], div_take};
      div_pack = round_pack(op_sign, op_exp, {quot, quot_sticky}, op_rm);
      next_res_flags_only = res_flags_only;
      next_res_guard = res_guard;
      next_res_data = res_data;
      next_res_flags = res_flags;
      // Result is parked here well before the next issue can overwrite op
      if (quot_done) begin
         next_res_flags_only = op_flags_only;
         next_res_guard = op_guard;
         next_res_data = op_spec ? op_spec_res : div_pack[31:0];
         next_res_flags = op_spec ? op_spec_flags
                                  : div_pack[FLAG_W+31:32];
         next_res_flags[F_IN_FLUSH] = op_spec_flags[F_IN_FLUSH];
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         op_flags_only <= 1'b0;
         op_guard <= 1'b0;
         op_spec <= 1'b0;
         op_sign <= 1'b0;
         op_spec_res <= '0;
         op_spec_flags <= '0;
         op_exp <= '0;
         op_rm <= RM_NEAREST;
         tok <= '0;
         recov <= '0;
         res_flags_only <= 1'b0;
         res_guard <= 1'b0;
         res_data <= '0;
         res_flags <= '0;
      end else if (CE) begin
         op_flags_only <= next_op_flags_only;
         op_guard <= next_op_guard;
         op_spec <= next_op_spec;
         op_sign <= next_op_sign;
         op_spec_res <= next_op_spec_res;
         op_spec_flags <= next_op_spec_flags;
         op_exp <= next_op_exp;
         op_rm <= next_op_rm;
         tok <= next_tok;
         recov <= next_recov;
         res_flags_only <= next_res_flags_only;
         res_guard <= next_res_guard;
         res_data <= next_res_data;
         res_flags <= next_res_flags;
      end
   end

   assign DIV_WB_VALID = tok[DIV_LATENCY-1] && res_guard;
   assign DIV_WB_DATA = res_flags_only ? {25'h0, res_flags}
                                       : res_data;

   // ----------------------------------------
   // Status word exception flags
   // ----------------------------------------
   logic [FLAG_W-1:0] next_psw;
   logic psw_from_div;

   always_comb begin
      // Flags-only results never reach the status word
      psw_from_div = DIV_WB_VALID && !res_flags_only;
      next_psw = PSW_WRITE ? PSW_WRITE_FLAGS : PROGRAM_STATUS_WORD_FLAGS;
      // Sets applied after the write so a same-cycle event is not lost
      next_psw = next_psw | OTHER_FLAG_SET;
      if (psw_from_div) begin
         next_psw = next_psw | res_flags;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PROGRAM_STATUS_WORD_FLAGS <= FLAGS_RESET;
      end else if (CE) begin
         PROGRAM_STATUS_WORD_FLAGS <= next_psw;
      end
   end
endmodule

// ==== tb/fpf_issue_model.sv ====
module fpf_issue_model
   import fpf_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic issue,
   output logic may_issue
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // Recovery spacing
   // ----------
   // One cycle more cautious than needed, never early
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   always_comb begin
      next_cnt = cnt;
      if (issue && may_issue) begin
         next_cnt = 5'(DIV_RECOVERY);
      end else if (cnt != 5'h00) begin
         next_cnt = cnt - 5'h01;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 5'h00;
      end else begin
         cnt <= next_cnt;
      end
   end
   assign may_issue = (cnt == 5'h00);
endmodule

// ==== tb/fpf_unit_bench.sv ====
module fpf_unit_bench
   import fpf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] DV = OP_DIVIDE;
   localparam logic [7:0] DF = OP_DIV_FLAGS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic ai = 1'b0, ag = 1'b0, di = 1'b0, dg = 1'b0, pw = 1'b0;
   logic [1:0] rm = 2'h0;
   logic [7:0] ao = 8'h00, dop = 8'h00;
   logic [31:0] a1 = 32'h0, a2 = 32'h0, d1 = 32'h0, d2 = 32'h0;
   logic [6:0] pf = 7'h00, of = 7'h00;
   logic awv, dr, dwv, may;
   logic [31:0] awd, dwd;
   logic [6:0] flg;
   int fails = 0;
   int n_checks = 0;
   fpf_unit dut_u (
      .CLK(clk), .SYS_RST(rst), .CE(ce), .ROUND_MODE(rm),
      .ALU_ISSUE(ai), .ALU_OPCODE(ao), .ALU_FIRST_SOURCE(a1),
      .ALU_SECOND_SOURCE(a2), .ALU_GUARD(ag), .ALU_WB_VALID(awv),
      .ALU_WB_DATA(awd), .DIV_ISSUE(di), .DIV_OPCODE(dop),
      .DIV_FIRST_SOURCE(d1), .DIV_SECOND_SOURCE(d2), .DIV_GUARD(dg),
      .DIV_READY(dr), .DIV_WB_VALID(dwv), .DIV_WB_DATA(dwd),
      .PSW_WRITE(pw), .PSW_WRITE_FLAGS(pf), .OTHER_FLAG_SET(of),
      .PROGRAM_STATUS_WORD_FLAGS(flg)
   );
   fpf_issue_model far_u (.clk(clk), .rst(rst), .issue(di), .may_issue(may));
   // ----------
   // Helpers
   // ----------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic clr();
      @(posedge clk);
      pw <= 1'b1;
      pf <= 7'h00;
      @(posedge clk);
      pw <= 1'b0;
      #1;
      chk(32'(flg), 32'h0);
   endtask
   // Issue, then judge write at c17 and status flags at c18
   task automatic dv(input logic [7:0] op, input logic [31:0] a, b,
         input logic g, input logic [31:0] ed, input logic [6:0] ep);
      int k;
      for (k = 0; !may && k < 40; k++) @(posedge clk);
      if (!may) begin
         fails++;
         print_verdict();
      end
      @(posedge clk);
      di <= 1'b1;
      dop <= op;
      d1 <= a;
      d2 <= b;
      dg <= g;
      @(posedge clk);
      di <= 1'b0;
      repeat (16) @(posedge clk);
      #1;
      chk(32'(dwv), 32'(g));
      if (g) chk(dwd, ed);
      @(posedge clk);
      #1;
      chk(32'(flg), 32'(ep));
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic add_flags();
      logic [31:0] xa [7];
      logic [31:0] xb [7];
      logic [6:0] xe [5];
      xa = '{32'h7F7FFFFF, 32'h7F7FFFFF, 32'h00A00000, 32'h7F800000,
         32'h40400000, 32'h7F7FFFFF, 32'h3F800000};
      xb = '{32'h3F800000, 32'h7F7FFFFF, 32'h80800000, 32'hFF800000,
         32'h00400000, 32'h7F7FFFFF, 32'h3F800000};
      xe = '{7'h02, 7'h0A, 7'h46, 7'h10, 7'h20};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         ai <= (i < 7);
         ao <= (i == 6) ? 8'h16 : OP_ADD_FLAGS;
         ag <= (i != 5);
         a1 <= xa[i % 7];
         a2 <= xb[i % 7];
         #1;
         if (i >= 3) chk(32'(awv), 32'(i < 8));
         if (i >= 3 && i < 8) chk(awd, {25'h0, xe[i - 3]});
      end
      chk(32'(flg), 32'h0);
   endtask
   task automatic round_modes();
      logic [31:0] q [4];
      q = '{32'h3EAAAAAB, 32'h3EAAAAAA, 32'h3EAAAAAB, 32'h3EAAAAAA};
      clr();
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         rm <= 2'(m);
         dv(DV, 32'h3F800000, 32'h40400000, 1'b1, q[m], 7'h02);
      end
      @(posedge clk);
      rm <= RM_NEAREST;
   endtask
   task automatic sticky();
      clr();
      @(posedge clk);
      of <= 7'h04;
      @(posedge clk);
      of <= 7'h02;
      ce <= 1'b0;
      #1;
      chk(32'(flg), 32'h04);
      @(posedge clk);
      ce <= 1'b1;
      #1;
      chk(32'(flg), 32'h04);
      dv(DV, 32'h40400000, 32'h0, 1'b1, 32'h7F800000, 7'h07);
      @(posedge clk);
      pw <= 1'b1;
      pf <= 7'h08;
      of <= 7'h40;
      @(posedge clk);
      pw <= 1'b0;
      of <= 7'h00;
      #1;
      chk(32'(flg), 32'h48);
   endtask
   // Far side breaks the spacing on purpose: only one op may land
   task automatic refused();
      int n;
      n = 0;
      @(posedge clk);
      di <= 1'b1;
      dop <= DV;
      d1 <= 32'h3F800000;
      d2 <= 32'h3F800000;
      dg <= 1'b1;
      @(posedge clk);
      d1 <= 32'h40400000;
      #1;
      chk(32'(dr), 32'h0);
      repeat (14) @(posedge clk);
      di <= 1'b0;
      repeat (22) begin
         @(posedge clk);
         #1;
         n += int'(dwv);
      end
      chk(32'(n), 32'h1);
      chk(dwd, 32'h3F800000);
   endtask
   initial begin
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      add_flags();
      dv(DV, 32'hC0400000, 32'h3F800000, 1'b1, 32'hC0400000, 7'h00);
      dv(DV, 32'h40400000, 32'hC0400000, 1'b1, 32'hBF800000, 7'h00);
      dv(DV, 32'h40400000, 32'h0, 1'b0, 32'h0, 7'h00);
      dv(DV, 32'h40400000, 32'h00800000, 1'b1, 32'h7F400000, 7'h00);
      dv(DV, 32'h40400000, 32'h00400000, 1'b1, 32'h7F800000, 7'h21);
      dv(DV, 32'h7F800000, 32'hFF800000, 1'b1, 32'hFFFFFFFF, 7'h31);
      dv(DV, 32'h00800000, 32'h40000000, 1'b1, 32'h0, 7'h77);
      clr();
      dv(DF, 32'h7F7FFFFF, 32'h3E000000, 1'b1, 32'h0A, 7'h00);
      dv(DF, 32'h40400000, 32'h00400000, 1'b1, 32'h21, 7'h00);
      dv(DF, 32'h00800000, 32'h40000000, 1'b1, 32'h46, 7'h00);
      dv(DF, 32'h7F800000, 32'hFF800000, 1'b0, 32'h0, 7'h00);
      round_modes();
      sticky();
      refused();
      print_verdict();
   end
endmodule

// ==== tb/fpf_unit_monitor.sv ====
module fpf_unit_monitor
   import fpf_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic ALU_ISSUE,
   input wire logic [7:0] ALU_OPCODE,
   input wire logic ALU_GUARD,
   input wire logic ALU_WB_VALID,
   input wire logic [31:0] ALU_WB_DATA,
   input wire logic DIV_ISSUE,
   input wire logic [7:0] DIV_OPCODE,
   input wire logic DIV_GUARD,
   input wire logic DIV_READY,
   input wire logic DIV_WB_VALID,
   input wire logic PSW_WRITE,
   input wire logic [FLAG_W-1:0] OTHER_FLAG_SET,
   input wire logic [FLAG_W-1:0] PROGRAM_STATUS_WORD_FLAGS
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // Taken issues
   // ----------
   logic dtk;
   logic atk;
   logic [FLAG_W-1:0] fl;
   assign dtk = CE && DIV_ISSUE && DIV_READY
      && (DIV_OPCODE == OP_DIVIDE || DIV_OPCODE == OP_DIV_FLAGS);
   assign atk = CE && ALU_ISSUE && ALU_GUARD && ALU_OPCODE == OP_ADD_FLAGS;
   assign fl = PROGRAM_STATUS_WORD_FLAGS;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // ----------
   // Checks
   // ----------
   a_div_busy_early: assert property (dtk |=> !DIV_READY [*8])
      else $error("divider ready too early");
   a_div_busy_late: assert property (dtk |-> ##9 !DIV_READY [*7])
      else $error("divider ready inside recovery");
   a_div_ready_back: assert property (dtk |-> ##16 DIV_READY)
      else $error("divider not ready after recovery");
   a_div_wb_time: assert property (dtk && DIV_GUARD
      |-> ##17 DIV_WB_VALID)
      else $error("divide write not at latency");
   a_div_guard_off: assert property (dtk && !DIV_GUARD
      |-> ##17 !DIV_WB_VALID)
      else $error("guarded-off divide wrote");
   a_alu_latency: assert property (atk |-> ##3 ALU_WB_VALID)
      else $error("add flags write not at latency");
   a_alu_no_ghost: assert property (ALU_WB_VALID |-> $past(atk, 3))
      else $error("add flags write without taken issue");
   a_vec_upper_zero: assert property (ALU_WB_VALID
      |-> ALU_WB_DATA[31:7] == 25'h0)
      else $error("flag vector upper bits set");
   a_flags_sticky: assert property (!PSW_WRITE
      |=> (fl & $past(fl)) == $past(fl))
      else $error("status flag lost without write");
   a_flags_or_in: assert property (CE && OTHER_FLAG_SET != 7'h00
      |=> (fl & $past(OTHER_FLAG_SET)) == $past(OTHER_FLAG_SET))
      else $error("other flag update not merged");
   a_flags_cause: assert property ($changed(fl) |-> $past(PSW_WRITE)
      || $past(OTHER_FLAG_SET) != 7'h00 || $past(DIV_WB_VALID))
      else $error("status flags changed without cause");
   cov_div: cover property (dtk && DIV_GUARD);
   cov_alu: cover property (atk);
   cov_clash: cover property (PSW_WRITE && OTHER_FLAG_SET != 7'h00);
endmodule

bind fpf_unit fpf_unit_monitor mon_u (
   .CLK(CLK),
   .SYS_RST(SYS_RST),
   .CE(CE),
   .ALU_ISSUE(ALU_ISSUE),
   .ALU_OPCODE(ALU_OPCODE),
   .ALU_GUARD(ALU_GUARD),
   .ALU_WB_VALID(ALU_WB_VALID),
   .ALU_WB_DATA(ALU_WB_DATA),
   .DIV_ISSUE(DIV_ISSUE),
   .DIV_OPCODE(DIV_OPCODE),
   .DIV_GUARD(DIV_GUARD),
   .DIV_READY(DIV_READY),
   .DIV_WB_VALID(DIV_WB_VALID),
   .PSW_WRITE(PSW_WRITE),
   .OTHER_FLAG_SET(OTHER_FLAG_SET),
   .PROGRAM_STATUS_WORD_FLAGS(PROGRAM_STATUS_WORD_FLAGS)
);
